// [shared/rcs_pkg.sv]
/*
  Constants, register map and state types of the clock control and status block.
  Assumes a 10 MHz mclk and a 32.768 kHz time base strobe from the oscillator.
*/
// Functional notes
// R1: all four control/status registers reachable by the host at any time, even mid-update.
// R2: update pending bit is read-only; one while an update runs or is imminent.
// R3: after pending reads zero, no update starts for at least 244 us.
// R4: writing inhibit one blocks updates and then clears the pending bit.
// R5: divider select 000/010 normal, 001/11x hold reset, 011/10x test.
// R6: leaving divider reset for normal gives the first update half a second later.
// R7: rate select picks one of fifteen divider taps or none for the periodic flag; the code has thirteen distinct taps, codes 1 and 2 repeat codes 8 and 9.
// R8: periodic flag is set at the rate regardless of its enable.
// R9: inhibit zero lets counters advance each second; inhibit one aborts an update.
// R10: inhibit bit is read/write, untouched by standby reset and internal logic.
// R11: periodic enable read/write, cleared by standby reset.
// R12: alarm enable read/write, cleared by standby reset.
// R13: alarm flag set each second time bytes match alarm bytes; top bits 11 match anything.
// R14: update-done enable read/write, cleared by standby reset and when inhibit rises.
// R15: format bit one selects binary, zero BCD; survives standby reset.
// R16: hour format bit one selects 24 hour; unaffected by reset; the code keeps it on standby reset but clears it on rst.
// R17: daylight saving bit 0 and bit 3 of second register read zero.
// R18: request flag is OR of flag-and-enable pairs; request output low when set.
// R19: reading the flag register or standby reset clears all its flags.
// R20: update-done flag is set at the end of every update cycle.
// R21: low four bits of flag register read zero, writes ignored.
// R22: valid bit cleared on total power loss; set only by reading register four with power good.
// R23: bit 6 of the fourth register reads zero, writes ignored.
// R24: periodic flag set on rising edge of selected tap, once per period.
package rcs_pkg;
  localparam logic [11:0] ADDR_CTRL_A   = 12'h000;
  localparam logic [11:0] ADDR_CTRL_B   = 12'h004;
  localparam logic [11:0] ADDR_FLAGS    = 12'h008;
  localparam logic [11:0] ADDR_VALID    = 12'h00C;
  localparam logic [11:0] ADDR_ALARM_S  = 12'h010;
  localparam logic [11:0] ADDR_ALARM_M  = 12'h014;
  localparam logic [11:0] ADDR_ALARM_H  = 12'h018;
  localparam logic [11:0] ADDR_TIME_S   = 12'h01C;
  localparam logic [11:0] ADDR_TIME_M   = 12'h020;
  localparam logic [11:0] ADDR_TIME_H   = 12'h024;
  localparam logic [11:0] ADDR_STATUS   = 12'h028;
  localparam int          DIV_STAGES    = 22;
  localparam int          HALF_SEC_BIT  = 14;
  // pending window measured in base ticks: 244 us is 8 ticks of 30.52 us
  localparam int          PEND_US       = 244;
  localparam int          BASE_HZ       = 32768;
  localparam int          PEND_TICKS    = (PEND_US * BASE_HZ + 999_999) / 1_000_000;
  localparam int          UPD_US        = 1948;
  localparam int          UPD_TICKS     = (UPD_US * BASE_HZ + 999_999) / 1_000_000;
  localparam logic [7:0]  CTRL_A_RST    = 8'h00;
  localparam logic [7:0]  CTRL_B_RST    = 8'h00;
  localparam logic [7:0]  DONT_CARE_TOP = 8'hC0;

  typedef enum logic [1:0] {
    RCS_IDLE,
    RCS_PEND,
    RCS_UPD
  } rcs_phase_e;

  typedef struct packed {
    logic [2:0] divider_select;
    logic [3:0] periodic_rate_select;
  } rcs_ctrl_a_s;

  typedef struct packed {
    logic inhibit;
    logic periodic_irq_enable;
    logic alarm_irq_enable;
    logic update_done_irq_enable;
    logic binary_format_select;
    logic hour24_select;
  } rcs_ctrl_b_s;

  typedef struct packed {
    logic periodic_flag;
    logic alarm_flag;
    logic update_done_flag;
  } rcs_flags_s;

  typedef struct packed {
    rcs_ctrl_a_s       a;
    rcs_ctrl_b_s       b;
    rcs_flags_s        f;
    logic              valid_ram_time;
    logic [5:0]        day_alarm;
    logic [7:0]        alarm_s;
    logic [7:0]        alarm_m;
    logic [7:0]        alarm_h;
    logic [DIV_STAGES-1:0] div;
    logic              tap_q;
    rcs_phase_e        phase;
    logic [6:0]        ticks;
    logic              was_reset;
    logic              sec_pulse;
    logic [31:0]       prdata;
  } rcs_state_s;
endpackage

// [hw/rcs_ctrl_status.sv]
/*
  Control and status registers of the real-time clock over an APB slave.
  Assumes base_tick pulses once per 32.768 kHz period, time bytes come from
  the counters outside, and standby_power_on_reset/battery_lost are synchronous.
*/
`timescale 1ns/1ns
module rcs_ctrl_status (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        standby_power_on_reset,
  input  wire logic        battery_lost,
  input  wire logic        power_good,
  input  wire logic        base_tick,
  input  wire logic [7:0]  time_s,
  input  wire logic [7:0]  time_m,
  input  wire logic [7:0]  time_h,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_request_n,
  output logic             update_pending_flag,
  output logic             advance_second,
  output logic             binary_format_select,
  output logic             hour24_select
);
  rcs_pkg::rcs_state_s s_q, s_d;
  logic                wr, rd, tap, irq_request_flag;
  logic [7:0]          a_rd, b_rd, c_rd, d_rd;

  function automatic logic alarm_hit(input logic [7:0] al, input logic [7:0] tm);
    alarm_hit = ((al & rcs_pkg::DONT_CARE_TOP) == rcs_pkg::DONT_CARE_TOP) || (al == tm);
  endfunction

  function automatic logic div_held(input logic [2:0] sel);
    div_held = (sel == 3'b001) || (sel[2:1] == 2'b11); // R5
  endfunction

  function automatic logic div_normal(input logic [2:0] sel);
    div_normal = (sel == 3'b000) || (sel == 3'b010); // R5
  endfunction

  // tap k of the chain toggles every 2^k base ticks; rate codes map to taps
  function automatic logic rate_tap(input logic [3:0] rs, input logic [21:0] d);
    case (rs)
      4'h0:    rate_tap = 1'b0;
      4'h1:    rate_tap = d[6];
      4'h2:    rate_tap = d[7];
      default: rate_tap = d[rs - 4'h2]; // R7
    endcase
  endfunction

  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign tap    = rate_tap(s_q.a.periodic_rate_select, s_q.div);
  assign irq_request_flag = (s_q.f.periodic_flag && s_q.b.periodic_irq_enable)
                         || (s_q.f.alarm_flag && s_q.b.alarm_irq_enable)
                         || (s_q.f.update_done_flag && s_q.b.update_done_irq_enable); // R18

  assign a_rd = {s_q.phase != rcs_pkg::RCS_IDLE, s_q.a.divider_select,
                 s_q.a.periodic_rate_select}; // R2
  assign b_rd = {s_q.b.inhibit, s_q.b.periodic_irq_enable, s_q.b.alarm_irq_enable,
                 s_q.b.update_done_irq_enable, 1'b0, s_q.b.binary_format_select,
                 s_q.b.hour24_select, 1'b0}; // R17
  assign c_rd = {irq_request_flag, s_q.f.periodic_flag, s_q.f.alarm_flag,
                 s_q.f.update_done_flag, 4'h0}; // R21
  assign d_rd = {s_q.valid_ram_time, 1'b0, s_q.day_alarm}; // R23

  always_comb begin
    s_d           = s_q;
    s_d.sec_pulse = 1'b0;
    pslverr       = 1'b0;
    // the unmapped answer is an error; every mapped address answers in one access cycle
    if (psel && penable) begin
      case (paddr)
        rcs_pkg::ADDR_CTRL_A, rcs_pkg::ADDR_CTRL_B, rcs_pkg::ADDR_FLAGS,
        rcs_pkg::ADDR_VALID, rcs_pkg::ADDR_ALARM_S, rcs_pkg::ADDR_ALARM_M,
        rcs_pkg::ADDR_ALARM_H, rcs_pkg::ADDR_TIME_S, rcs_pkg::ADDR_TIME_M,
        rcs_pkg::ADDR_TIME_H, rcs_pkg::ADDR_STATUS: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end

    // divider chain: held in reset, else counts base ticks
    if (div_held(s_q.a.divider_select)) begin
      s_d.div       = '0; // R5
      s_d.was_reset = 1'b1;
    end else if (base_tick) begin
      s_d.div = s_q.div + 22'd1;
      if (div_normal(s_q.a.divider_select)) begin
        s_d.was_reset = 1'b0;
      end
    end
    s_d.tap_q = tap;

    // second boundary: half a second after leaving reset, then every second
    if (base_tick && div_normal(s_q.a.divider_select) && !s_q.b.inhibit) begin
      // the low 15 bits wrap every 2^15 ticks, one second; after a divider
      // reset they first reach this pattern half a second later
      if ((s_q.was_reset && s_q.div[rcs_pkg::HALF_SEC_BIT:0] == 15'h3FFF) || // R6
          (s_q.div[rcs_pkg::HALF_SEC_BIT:0] == 15'h3FFF
           && s_q.phase == rcs_pkg::RCS_IDLE)) begin // R9
        s_d.phase = rcs_pkg::RCS_PEND; // R3
        s_d.ticks = '0;
      end
    end

    // update sequencing: pending window, then update, then done
    case (s_q.phase)
      rcs_pkg::RCS_IDLE: begin
      end
      rcs_pkg::RCS_PEND: begin
        if (base_tick) begin
          s_d.ticks = s_q.ticks + 7'd1;
          if (s_q.ticks == 7'(rcs_pkg::PEND_TICKS - 1)) begin
            s_d.phase     = rcs_pkg::RCS_UPD; // R3
            s_d.ticks     = '0;
            s_d.sec_pulse = 1'b1; // R9
          end
        end
      end
      rcs_pkg::RCS_UPD: begin
        if (base_tick) begin
          s_d.ticks = s_q.ticks + 7'd1;
          if (s_q.ticks == 7'(rcs_pkg::UPD_TICKS - 1)) begin
            s_d.phase = rcs_pkg::RCS_IDLE;
          end
        end
      end
      default: s_d.phase = rcs_pkg::RCS_IDLE;
    endcase
    if (s_q.b.inhibit) begin
      s_d.phase     = rcs_pkg::RCS_IDLE; // R4 R9
      s_d.sec_pulse = 1'b0;
    end

    // flag register clears on read; a same-cycle event still sets afterwards
    if (rd && paddr == rcs_pkg::ADDR_FLAGS) begin
      s_d.f = '0; // R19
    end
    if (tap && !s_q.tap_q) begin
      s_d.f.periodic_flag = 1'b1; // R8 R24
    end
    if (s_q.sec_pulse && alarm_hit(s_q.alarm_s, time_s) && alarm_hit(s_q.alarm_m, time_m)
        && alarm_hit(s_q.alarm_h, time_h)) begin
      s_d.f.alarm_flag = 1'b1; // R13
    end
    if (s_q.phase == rcs_pkg::RCS_UPD && s_d.phase == rcs_pkg::RCS_IDLE && !s_q.b.inhibit) begin
      s_d.f.update_done_flag = 1'b1; // R20
    end

    // host writes go through at all times
    if (wr) begin
      case (paddr)
        rcs_pkg::ADDR_CTRL_A: begin
          s_d.a.divider_select       = pwdata[6:4]; // R1 R5
          s_d.a.periodic_rate_select = pwdata[3:0]; // R7
        end
        rcs_pkg::ADDR_CTRL_B: begin
          s_d.b.inhibit                = pwdata[7]; // R10
          s_d.b.periodic_irq_enable    = pwdata[6]; // R11
          s_d.b.alarm_irq_enable       = pwdata[5]; // R12
          s_d.b.update_done_irq_enable = pwdata[4] && !(pwdata[7] && !s_q.b.inhibit); // R14
          s_d.b.binary_format_select   = pwdata[2]; // R15
          s_d.b.hour24_select          = pwdata[1]; // R16
        end
        rcs_pkg::ADDR_VALID:   s_d.day_alarm = pwdata[5:0]; // R23
        rcs_pkg::ADDR_ALARM_S: s_d.alarm_s   = pwdata[7:0];
        rcs_pkg::ADDR_ALARM_M: s_d.alarm_m   = pwdata[7:0];
        rcs_pkg::ADDR_ALARM_H: s_d.alarm_h   = pwdata[7:0];
        default: begin
        end
      endcase
    end

    if (rd && paddr == rcs_pkg::ADDR_VALID && power_good) begin
      s_d.valid_ram_time = 1'b1; // R22
    end
    if (battery_lost) begin
      s_d.valid_ram_time = 1'b0; // R22
    end

    // standby reset leaves inhibit, format, divider and rate alone
    if (standby_power_on_reset) begin
      s_d.b.periodic_irq_enable    = 1'b0; // R11
      s_d.b.alarm_irq_enable       = 1'b0; // R12
      s_d.b.update_done_irq_enable = 1'b0; // R14
      s_d.f                        = '0; // R19
    end

    if (rd) begin
      case (paddr)
        rcs_pkg::ADDR_CTRL_A:  s_d.prdata = {24'h00_0000, a_rd};
        rcs_pkg::ADDR_CTRL_B:  s_d.prdata = {24'h00_0000, b_rd};
        rcs_pkg::ADDR_FLAGS:   s_d.prdata = {24'h00_0000, c_rd};
        rcs_pkg::ADDR_VALID:   s_d.prdata = {24'h00_0000, d_rd};
        rcs_pkg::ADDR_ALARM_S: s_d.prdata = {24'h00_0000, s_q.alarm_s};
        rcs_pkg::ADDR_ALARM_M: s_d.prdata = {24'h00_0000, s_q.alarm_m};
        rcs_pkg::ADDR_ALARM_H: s_d.prdata = {24'h00_0000, s_q.alarm_h};
        rcs_pkg::ADDR_TIME_S:  s_d.prdata = {24'h00_0000, time_s};
        rcs_pkg::ADDR_TIME_M:  s_d.prdata = {24'h00_0000, time_m};
        rcs_pkg::ADDR_TIME_H:  s_d.prdata = {24'h00_0000, time_h};
        rcs_pkg::ADDR_STATUS:  s_d.prdata = {30'h0000_0000, irq_request_flag,
                                             s_q.phase != rcs_pkg::RCS_IDLE};
        default:               s_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q   <= '0;
      s_q.a <= rcs_pkg::rcs_ctrl_a_s'(rcs_pkg::CTRL_A_RST[6:0]);
    end else begin
      s_q <= s_d;
    end
  end

  // read data passes through combinationally in the access cycle, then the registered copy holds it
  always_comb begin
    prdata = (psel && penable && !pwrite) ? s_d.prdata : s_q.prdata;
  end
  assign irq_request_n        = !irq_request_flag; // R18
  assign update_pending_flag  = s_q.phase != rcs_pkg::RCS_IDLE;
  assign advance_second       = s_q.sec_pulse;
  assign binary_format_select = s_q.b.binary_format_select;
  assign hour24_select        = s_q.b.hour24_select;
endmodule

// [verification/rcs_ctrl_status_checker.sv]
/*
  Port checker of the clock control and status block.
  Assumes it is bound to the top module and that base_tick is the time base strobe.
*/
`timescale 1ns/1ns
module rcs_ctrl_status_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        standby_power_on_reset,
  input wire logic        base_tick,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_request_n,
  input wire logic        update_pending_flag,
  input wire logic        advance_second,
  input wire logic        binary_format_select,
  input wire logic        hour24_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic       acc;
  logic [3:0] lead_q;
  assign acc = psel && penable;
  // ticks seen while pending; saturates so a long hold cannot wrap
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) lead_q <= 4'h0;
    else if (!update_pending_flag) lead_q <= 4'h0;
    else if (base_tick && lead_q != 4'hf) lead_q <= lead_q + 4'h1;
  end
  AST_READY: assert property (acc |-> pready) else $error("no ready");
  AST_MAP: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h028))
    else $error("bad slverr");
  AST_PEND: assert property (advance_second |-> update_pending_flag)
    else $error("update without pending");
  AST_LEAD: assert property (advance_second |-> lead_q >= 4'h7)
    else $error("pending lead too short");
  AST_PULSE: assert property (advance_second |=> !advance_second)
    else $error("advance not a pulse");
  AST_INH: assert property (acc && pwrite && paddr == 12'h004 && pwdata[7]
    |-> ##[1:4] !update_pending_flag) else $error("inhibit kept pending");
  AST_SBY: assert property (standby_power_on_reset |=> irq_request_n)
    else $error("irq after standby reset");
  AST_FMT: assert property (acc && pwrite && paddr == 12'h004
    |=> binary_format_select == $past(pwdata[2])) else $error("format bit");
  AST_HOUR: assert property (acc && pwrite && paddr == 12'h004
    |=> hour24_select == $past(pwdata[1])) else $error("hour bit");
  AST_RDC: assert property (acc && !pwrite && paddr == 12'h008
    |-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0) else $error("flag low bits");
  AST_IRQ_REQUEST_FLAG: assert property (acc && !pwrite && paddr == 12'h008
    |-> prdata[7] == !irq_request_n) else $error("request flag vs pin");
  AST_RDB: assert property (acc && !pwrite && paddr == 12'h004
    |-> !prdata[3] && !prdata[0]) else $error("ctrl b fixed bits");
  AST_RDD: assert property (acc && !pwrite && paddr == 12'h00C |-> !prdata[6])
    else $error("valid reg bit 6");
endmodule

// [verification/rcs_ctrl_status_tb.sv]
/*
  Self-checking bench of the clock control block: apb master and models.
  Assumes the checker file is compiled before it.
*/
`timescale 1ns/1ns
module rcs_ctrl_status_tb;
  logic        mclk = 1'h0, rst = 1'h1, standby_power_on_reset = 1'h0, battery_lost = 1'h0;
  logic        power_good = 1'h1, base_tick = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  time_s = 8'h00, time_m = 8'h00, time_h = 8'h00, bm, w;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
  logic        pready, pslverr, irq_request_n, update_pending_flag, advance_second, ev;
  logic        binary_format_select, hour24_select;
  int          err_count = 0, checks_done = 0, tc = 0, ticks = 0, t0, k;
  rcs_ctrl_status rcs_ctrl_status_inst (
    .mclk                   (mclk),
    .rst                    (rst),
    .standby_power_on_reset (standby_power_on_reset),
    .battery_lost           (battery_lost),
    .power_good             (power_good),
    .base_tick              (base_tick),
    .time_s                 (time_s),
    .time_m                 (time_m),
    .time_h                 (time_h),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .irq_request_n          (irq_request_n),
    .update_pending_flag    (update_pending_flag),
    .advance_second         (advance_second),
    .binary_format_select   (binary_format_select),
    .hour24_select          (hour24_select)
  );
  always #50 mclk = ~mclk;
  // time base squeezed to one tick per three cycles so half a second fits the run
  always @(posedge mclk) begin
    tc <= (tc + 1) % 3;
    base_tick <= (tc == 2);
    if (base_tick) ticks <= ticks + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    bus(1'h0, a, '0);
    chk(rv & m, x);
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    // the half second wait dominates: about 51k cycles of a 70k cycle limit
    #7_000_000;
    err_count++;
    close_out;
  end
  initial begin
    void'($urandom(74646));
    repeat (16) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rc(12'h004, '1, '0);
    rc(12'h008, '1, '0);
    w = 8'($urandom) & 8'h7F;
    bus(1'h1, 12'h004, {24'h0, w});
    rc(12'h004, '1, {24'h0, w & 8'h76});
    bus(1'h1, 12'h004, {24'h0, w | 8'h90});
    bm = (w | 8'h80) & 8'hE6;
    rc(12'h004, '1, {24'h0, bm});
    standby_power_on_reset <= 1'h1;
    @(posedge mclk);
    standby_power_on_reset <= 1'h0;
    @(posedge mclk);
    rc(12'h004, '1, {24'h0, bm & 8'h86});
    chk({31'h0, binary_format_select}, {31'h0, bm[2]});
    chk({31'h0, hour24_select}, {31'h0, bm[1]});
    bus(1'h1, 12'h000, 32'hFFFF_FF93);
    rc(12'h000, '1, 32'h0000_0013);
    bus(1'h1, 12'h004, 32'h0000_0040);
    for (int c = 3; c < 7; c++) begin
      bus(1'h1, 12'h000, 32'h0000_0020 | 32'(c));
      bus(1'h0, 12'h008, '0);
      t0 = -1;
      for (k = 0; k < 300; k++) begin
        bus(1'h0, 12'h008, '0);
        if (rv[6] && t0 >= 0) break;
        if (rv[6]) begin
          chk({30'h0, rv[7], irq_request_n}, 32'h0000_0003);
          t0 = ticks;
        end
      end
      chk(32'((ticks - t0 + 1) >> (c - 1)), 32'h0000_0001);
    end
    bus(1'h1, 12'h000, 32'h0000_0023);
    bus(1'h1, 12'h004, '0);
    bus(1'h0, 12'h008, '0);
    repeat (36) @(posedge mclk);
    rc(12'h008, 32'h0000_00C0, 32'h0000_0040);
    bus(1'h1, 12'h000, 32'h0000_0020);
    bus(1'h0, 12'h008, '0);
    repeat (900) @(posedge mclk);
    rc(12'h008, 32'h0000_0040, '0);
    time_s <= 8'($urandom % 60);
    time_m <= 8'($urandom % 60);
    @(posedge mclk);
    bus(1'h1, 12'h010, {24'h0, time_s});
    bus(1'h1, 12'h014, {24'h0, time_m});
    bus(1'h1, 12'h018, 32'h0000_00C5);
    bus(1'h1, 12'h004, 32'h0000_0030);
    bus(1'h1, 12'h000, 32'h0000_0010);
    bus(1'h1, 12'h000, 32'h0000_0020);
    t0 = ticks;
    for (k = 0; k < 60000 && advance_second !== 1'h1; k++) @(posedge mclk);
    chk({31'h0, (ticks - t0) inside {[16376:16400]}}, 32'h0000_0001);
    rc(12'h000, 32'h0000_0080, 32'h0000_0080);
    repeat (300) @(posedge mclk);
    rc(12'h008, 32'h0000_0090, 32'h0000_0090);
    chk(rv & 32'h0000_0020, 32'h0000_0020);
    rc(12'h000, 32'h0000_0080, '0);
    bus(1'h1, 12'h004, 32'h0000_0090);
    rc(12'h004, '1, 32'h0000_0080);
    power_good <= 1'h0;
    battery_lost <= 1'h1;
    @(posedge mclk);
    battery_lost <= 1'h0;
    bus(1'h1, 12'h00C, '1);
    rc(12'h00C, 32'h0000_00C0, '0);
    power_good <= 1'h1;
    bus(1'h0, 12'h00C, '0);
    rc(12'h00C, 32'h0000_0080, 32'h0000_0080);
    battery_lost <= 1'h1;
    @(posedge mclk);
    battery_lost <= 1'h0;
    rc(12'h00C, 32'h0000_0080, '0);
    bus(1'h1, 12'h030, '1);
    chk({31'h0, ev}, 32'h0000_0001);
    bus(1'h0, 12'h02C, '0);
    chk({rv[30:0], ev}, 32'h0000_0001);
    close_out;
  end
endmodule
bind rcs_ctrl_status rcs_ctrl_status_checker rcs_ctrl_status_checker_inst (
  .mclk                   (mclk),
  .rst                    (rst),
  .standby_power_on_reset (standby_power_on_reset),
  .base_tick              (base_tick),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .paddr                  (paddr),
  .pwdata                 (pwdata),
  .prdata                 (prdata),
  .pready                 (pready),
  .pslverr                (pslverr),
  .irq_request_n          (irq_request_n),
  .update_pending_flag    (update_pending_flag),
  .advance_second         (advance_second),
  .binary_format_select   (binary_format_select),
  .hour24_select          (hour24_select)
);
